// [logic/omc_defines.vh]
`ifndef OMC_DEFINES_VH
`define OMC_DEFINES_VH

// Operating modes
`define OMC_MODE_W 3
`define OMC_MODE_RESET 3'h0
`define OMC_MODE_RUN 3'h1
`define OMC_MODE_HALT 3'h2
`define OMC_MODE_WAIT 3'h3
`define OMC_MODE_STOP_RET 3'h4
`define OMC_MODE_STOP_DEEP 3'h5

// Reset vector location
`define OMC_RESET_VECTOR 16'hfffe

// Register byte addresses
`define OMC_ADDR_CTRL 12'h000
`define OMC_ADDR_STAT 12'h004
`define OMC_ADDR_ACK 12'h008

// Control register fields
`define OMC_CTRL_STOP_ENABLE_BIT 0
`define OMC_CTRL_DBGEN 1
`define OMC_CTRL_VDE 2
`define OMC_CTRL_VDSE 3
`define OMC_CTRL_PPDS 4
`define OMC_CTRL_W 5
`define OMC_CTRL_RST 5'h01

// Debug command classes
`define OMC_CMD_W 3
`define OMC_CMD_MEM 3'h0
`define OMC_CMD_MEM_STAT 3'h1
`define OMC_CMD_DBG_REG 3'h2
`define OMC_CMD_HALT_REQ 3'h3
`define OMC_CMD_CPU_REG 3'h4
`define OMC_CMD_TRACE 3'h5
`define OMC_CMD_RESUME 3'h6

`endif

// [logic/omc_mode_ctrl.v]
`timescale 1ns/1ps
`include "omc_defines.vh"

module omc_mode_ctrl (
    input wire pclk,
    input wire presetn,
    input wire mode_pin_in,
    input wire debug_force_reset,
    input wire [`OMC_MODE_W-1:0] dummy_unused_mode,
    input wire halt_instr,
    input wire wait_instr,
    input wire stop_instr,
    input wire resume_done,
    input wire bkpt_dbg_ctrl,
    input wire bkpt_dbg_module,
    input wire irq_any,
    input wire irq_stop_wake,
    input wire periodic_wake,
    input wire reset_pin_asserted,
    input wire cmd_valid,
    input wire [`OMC_CMD_W-1:0] cmd_class,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    output reg [2:0] mode,
    output reg cpu_clk_en,
    output reg bus_clk_en,
    output reg debug_clk_en,
    output reg regulator_full,
    output reg ram_only_power,
    output reg pin_latch_closed,
    output reg clear_int_mask,
    output reg take_irq_stacking,
    output reg [15:0] fetch_vector,
    output reg fetch_start,
    output reg illegal_op_reset,
    output reg cmd_accept,
    output reg cmd_stop_wait_err,
    output reg cmd_mem_enable
);

    reg [2:0] mode_ff, nxt_mode;
    reg [`OMC_CTRL_W-1:0] ctrl_ff;
    reg partial_power_down_flag_ff, nxt_partial_power_down_flag;
    reg latch_ff, nxt_latch;
    reg deep_wake_ff;
    reg first_ff;
    wire halt_req;
    wire wr;
    wire stop_en;
    wire dbg_en;
    wire vd_both;
    wire ppds;

    // Command class is non-intrusive
    function nonintr;
        input [`OMC_CMD_W-1:0] c;
        begin
            nonintr = (c == `OMC_CMD_MEM) || (c == `OMC_CMD_MEM_STAT) ||
                      (c == `OMC_CMD_DBG_REG) || (c == `OMC_CMD_HALT_REQ);
        end
    endfunction

    assign stop_en = ctrl_ff[`OMC_CTRL_STOP_ENABLE_BIT];
    assign dbg_en = ctrl_ff[`OMC_CTRL_DBGEN];
    assign vd_both = ctrl_ff[`OMC_CTRL_VDE] & ctrl_ff[`OMC_CTRL_VDSE];
    assign ppds = ctrl_ff[`OMC_CTRL_PPDS];
    assign halt_req = cmd_valid && (cmd_class == `OMC_CMD_HALT_REQ);

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, never errors
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr = psel & penable & pwrite;

    // Read data is captured in the setup cycle so it stands from a flip-flop in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                `OMC_ADDR_CTRL: prdata <= {27'h000_0000, ctrl_ff};
                `OMC_ADDR_STAT: prdata <= {24'h00_0000, latch_ff, partial_power_down_flag_ff, 3'h0, mode_ff};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Config held across retained stop; deep-stop wake resets it like power-on
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `OMC_CTRL_RST;
        end else if (mode_ff == `OMC_MODE_RESET) begin
            ctrl_ff <= `OMC_CTRL_RST;
        end else if (wr && paddr == `OMC_ADDR_CTRL) begin
            ctrl_ff <= pwdata[`OMC_CTRL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer
    always @* begin
        nxt_mode = mode_ff;
        case (mode_ff)
            `OMC_MODE_RESET: begin
                if (mode_pin_in && !debug_force_reset)
                    nxt_mode = `OMC_MODE_RUN;
                else
                    nxt_mode = `OMC_MODE_HALT;
            end
            `OMC_MODE_RUN: begin
                if (halt_req || halt_instr || bkpt_dbg_ctrl || bkpt_dbg_module)
                    nxt_mode = `OMC_MODE_HALT;
                else if (wait_instr)
                    nxt_mode = `OMC_MODE_WAIT;
                else if (stop_instr && !stop_en)
                    nxt_mode = `OMC_MODE_RESET;
                else if (stop_instr && (dbg_en || !ppds || vd_both))
                    nxt_mode = `OMC_MODE_STOP_RET;
                else if (stop_instr)
                    nxt_mode = `OMC_MODE_STOP_DEEP;
            end
            `OMC_MODE_HALT: begin
                if (cmd_valid && cmd_class == `OMC_CMD_RESUME)
                    nxt_mode = `OMC_MODE_RUN;
            end
            `OMC_MODE_WAIT: begin
                if (halt_req)
                    nxt_mode = `OMC_MODE_HALT;
                else if (irq_any)
                    nxt_mode = `OMC_MODE_RUN;
            end
            `OMC_MODE_STOP_RET: begin
                if (reset_pin_asserted)
                    nxt_mode = `OMC_MODE_RESET;
                else if (halt_req && dbg_en)
                    nxt_mode = `OMC_MODE_HALT;
                else if (irq_stop_wake)
                    nxt_mode = `OMC_MODE_RUN;
            end
            `OMC_MODE_STOP_DEEP: begin
                if (reset_pin_asserted || periodic_wake)
                    nxt_mode = `OMC_MODE_RESET;
            end
            default: nxt_mode = `OMC_MODE_RESET;
        endcase
    end

    // Deep-stop flag and pin latch: wake sets, acknowledge clears; set wins
    always @* begin
        nxt_partial_power_down_flag = partial_power_down_flag_ff;
        nxt_latch = latch_ff;
        if (wr && paddr == `OMC_ADDR_ACK && pwdata[0]) begin
            nxt_partial_power_down_flag = 1'b0;
            nxt_latch = 1'b0;
        end
        if (nxt_mode == `OMC_MODE_STOP_DEEP)
            nxt_latch = 1'b1;
        if (mode_ff == `OMC_MODE_STOP_DEEP && nxt_mode == `OMC_MODE_RESET) begin
            nxt_partial_power_down_flag = 1'b1;
            nxt_latch = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= `OMC_MODE_RESET;
            partial_power_down_flag_ff <= 1'b0;
            latch_ff <= 1'b0;
            deep_wake_ff <= 1'b0;
            first_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            partial_power_down_flag_ff <= nxt_partial_power_down_flag;
            latch_ff <= nxt_latch;
            deep_wake_ff <= (mode_ff == `OMC_MODE_STOP_DEEP);
            first_ff <= (mode_ff != `OMC_MODE_RUN) && (nxt_mode == `OMC_MODE_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= `OMC_MODE_RESET;
            cpu_clk_en <= 1'b0;
            bus_clk_en <= 1'b1;
            debug_clk_en <= 1'b1;
            regulator_full <= 1'b1;
            ram_only_power <= 1'b0;
            pin_latch_closed <= 1'b0;
            clear_int_mask <= 1'b0;
            take_irq_stacking <= 1'b0;
            fetch_vector <= 16'h0000;
            fetch_start <= 1'b0;
            illegal_op_reset <= 1'b0;
        end else begin
            mode <= nxt_mode;
            // Halt keeps the CPU suspended; wait and stop gate it
            cpu_clk_en <= (nxt_mode == `OMC_MODE_RUN);
            // Stop halts the bus clock too; retained stop keeps all state
            bus_clk_en <= (nxt_mode != `OMC_MODE_STOP_RET) &&
                          (nxt_mode != `OMC_MODE_STOP_DEEP);
            debug_clk_en <= (nxt_mode != `OMC_MODE_STOP_DEEP) &&
                            ((nxt_mode != `OMC_MODE_STOP_RET) || dbg_en);
            // Regulator stays full for debug or voltage detect in stop
            regulator_full <= (nxt_mode != `OMC_MODE_STOP_DEEP) &&
                              ((nxt_mode != `OMC_MODE_STOP_RET) || dbg_en ||
                               vd_both);
            ram_only_power <= (nxt_mode == `OMC_MODE_STOP_DEEP);
            pin_latch_closed <= nxt_latch;
            clear_int_mask <= (mode_ff == `OMC_MODE_RUN) && wait_instr &&
                              (nxt_mode == `OMC_MODE_WAIT);
            take_irq_stacking <= (mode_ff != `OMC_MODE_RUN) &&
                                 (mode_ff != `OMC_MODE_RESET) &&
                                 (mode_ff != `OMC_MODE_HALT) &&
                                 (nxt_mode == `OMC_MODE_RUN);
            fetch_start <= (mode_ff == `OMC_MODE_RESET) && (nxt_mode == `OMC_MODE_RUN);
            fetch_vector <= `OMC_RESET_VECTOR;
            illegal_op_reset <= (mode_ff == `OMC_MODE_RUN) && stop_instr &&
                                !stop_en && (nxt_mode == `OMC_MODE_RESET);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debug command gating, answered in the cycle after the command
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_accept <= 1'b0;
            cmd_stop_wait_err <= 1'b0;
            cmd_mem_enable <= 1'b0;
        end else begin
            cmd_accept <= 1'b0;
            cmd_stop_wait_err <= 1'b0;
            cmd_mem_enable <= 1'b0;
            if (cmd_valid) begin
                case (mode_ff)
                    `OMC_MODE_RUN: begin
                        cmd_accept <= nonintr(cmd_class);
                        cmd_mem_enable <= (cmd_class == `OMC_CMD_MEM) ||
                                          (cmd_class == `OMC_CMD_MEM_STAT);
                    end
                    `OMC_MODE_HALT: begin
                        cmd_accept <= 1'b1;
                        cmd_mem_enable <= (cmd_class == `OMC_CMD_MEM) ||
                                          (cmd_class == `OMC_CMD_MEM_STAT);
                    end
                    `OMC_MODE_WAIT, `OMC_MODE_STOP_RET: begin
                        cmd_accept <= (cmd_class == `OMC_CMD_HALT_REQ) ||
                                      (cmd_class == `OMC_CMD_MEM_STAT);
                        cmd_stop_wait_err <= (cmd_class == `OMC_CMD_MEM_STAT);
                    end
                    default: begin
                        cmd_accept <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// [bench/omc_mode_ctrl_checker.sv]
`timescale 1ns/1ps
`include "omc_defines.vh"
module omc_mode_ctrl_checker (
    input logic pclk,
    input logic presetn,
    input logic mode_pin_in,
    input logic debug_force_reset,
    input logic wait_instr,
    input logic stop_instr,
    input logic periodic_wake,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [2:0] mode,
    input logic cpu_clk_en,
    input logic bus_clk_en,
    input logic debug_clk_en,
    input logic regulator_full,
    input logic pin_latch_closed,
    input logic clear_int_mask,
    input logic illegal_op_reset
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] ctl_ff;
    logic wr;
    logic sx;
    assign wr = psel && penable && pwrite;
    assign sx = mode == `OMC_MODE_RUN && stop_instr && ctl_ff[0];
    // Shadow of the control word; it falls back to its reset value in reset mode too
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) ctl_ff <= 5'h01;
        else if (mode == `OMC_MODE_RESET) ctl_ff <= 5'h01;
        else if (wr && paddr == `OMC_ADDR_CTRL) ctl_ff <= pwdata[4:0];
    end
    boot_mode_a: assert property (mode == `OMC_MODE_RESET |=>
        mode == ($past(mode_pin_in && !debug_force_reset) ? `OMC_MODE_RUN : `OMC_MODE_HALT))
        else $error("bad boot");
    stop_clocks_a: assert property (mode inside {`OMC_MODE_STOP_RET, `OMC_MODE_STOP_DEEP}
        |-> !bus_clk_en && !cpu_clk_en) else $error("clocks run in stop");
    stop_off_a: assert property (mode == `OMC_MODE_RUN && stop_instr && !ctl_ff[0]
        |=> illegal_op_reset && mode == `OMC_MODE_RESET) else $error("no illegal reset");
    stop_debug_a: assert property (sx && ctl_ff[1] |=> mode == `OMC_MODE_STOP_RET
        && debug_clk_en && regulator_full) else $error("debug stop wrong");
    stop_reg_a: assert property (sx && ctl_ff[4:1] == 4'h6 |=>
        mode == `OMC_MODE_STOP_RET && regulator_full) else $error("regulated stop wrong");
    stop_plain_a: assert property (sx && ctl_ff[4:1] inside {4'h0, 4'h2, 4'h4}
        |=> mode == `OMC_MODE_STOP_RET) else $error("plain stop wrong");
    stop_deep_a: assert property (sx && ctl_ff[4:1] inside {4'h8, 4'ha, 4'hc}
        |=> mode == `OMC_MODE_STOP_DEEP && pin_latch_closed) else $error("deep stop wrong");
    wait_entry_a: assert property (mode == `OMC_MODE_RUN && wait_instr |=>
        mode == `OMC_MODE_WAIT && clear_int_mask && !cpu_clk_en && bus_clk_en) else $error("wait");
    deep_wake_a: assert property (mode == `OMC_MODE_STOP_DEEP && periodic_wake
        |=> mode == `OMC_MODE_RESET ##1 pin_latch_closed) else $error("deep wake wrong");
    latch_hold_a: assert property (pin_latch_closed && !(wr && paddr == `OMC_ADDR_ACK
        && pwdata[0]) |=> pin_latch_closed) else $error("pin latch opened early");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind omc_mode_ctrl omc_mode_ctrl_checker omc_mode_ctrl_checker_inst (.pclk, .presetn,
    .mode_pin_in, .debug_force_reset, .wait_instr, .stop_instr, .periodic_wake, .psel, .penable,
    .pwrite, .paddr,
    .pwdata, .mode, .cpu_clk_en, .bus_clk_en, .debug_clk_en, .regulator_full,
    .pin_latch_closed, .clear_int_mask, .illegal_op_reset);

// [bench/omc_debug_host.sv]
`timescale 1ns/1ps
module omc_debug_host (
    input wire logic pclk,
    output logic cmd_valid = 1'h0,
    output logic [2:0] cmd_class = 3'h0
);
    // One-cycle frame; the class bus is scrambled after it so a stale class is never trusted
    task automatic issue(input logic [2:0] c);
        @(posedge pclk);
        cmd_valid <= 1'h1;
        cmd_class <= c;
        @(posedge pclk);
        cmd_valid <= 1'h0;
        cmd_class <= ~c;
    endtask
endmodule

// [bench/operating_mode_controller_tb_top.sv]
`timescale 1ns/1ps
`include "omc_defines.vh"
module operating_mode_controller_tb_top;
    localparam int RST = 0, RUN = 1, HLT = 2, WAI = 3, RET = 4, DEP = 5;
    logic pclk = 1'h0, presetn = 1'h0, mode_pin_in = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, dfr = 1'h0;
    wire pslverr, ram_only_power, fetch_start;
    logic [8:0] evs = 9'h000;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, r, seed = 32'h0000_eb91;
    logic [4:0] cv;
    wire cmd_valid, pready, cpu_clk_en, bus_clk_en, debug_clk_en, regulator_full;
    wire pin_latch_closed, clear_int_mask, take_irq_stacking, illegal_op_reset;
    wire cmd_accept, cmd_stop_wait_err, cmd_mem_enable;
    wire [2:0] cmd_class, mode;
    wire [31:0] prdata;
    wire [15:0] fetch_vector;
    int errors = 0, n_checks = 0, cyc = 0, md = 1, em;
    int cl[11] = '{4, 5, 6, 0, 1, 2, 3, 4, 5, 0, 6};
    int tbl[5] = '{0, 3, 13, 1, 17};
    omc_mode_ctrl omc_mode_ctrl_inst (.pclk, .presetn, .mode_pin_in, .debug_force_reset(dfr),
        .dummy_unused_mode(3'h0), .halt_instr(evs[0]), .wait_instr(evs[1]),
        .stop_instr(evs[2]), .resume_done(1'h0), .bkpt_dbg_ctrl(evs[3]),
        .bkpt_dbg_module(evs[4]), .irq_any(evs[5]), .irq_stop_wake(evs[6]),
        .periodic_wake(evs[7]), .reset_pin_asserted(evs[8]), .cmd_valid, .cmd_class, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .mode, .cpu_clk_en,
        .bus_clk_en, .debug_clk_en, .regulator_full, .ram_only_power, .pin_latch_closed,
        .clear_int_mask, .take_irq_stacking, .fetch_vector, .fetch_start, .illegal_op_reset,
        .cmd_accept, .cmd_stop_wait_err, .cmd_mem_enable);
    omc_debug_host omc_debug_host_inst (.pclk, .cmd_valid, .cmd_class);
    ////////////////////////////////////////////////////////////////////////////////
    always #2 pclk = ~pclk;
    // Hang guard; the whole run needs well under this many cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // APB master: request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        chk("slverr", pslverr, 0);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // One-cycle event pulse; outputs are looked at on the following falling edge
    task automatic ev(input int k);
        @(posedge pclk);
        evs <= 9'h001 << k;
        @(posedge pclk);
        evs <= 9'h000;
        @(negedge pclk);
    endtask
    // Debug command with the reference acceptance model beside it
    task automatic cmd(input int c);
        logic acc;
        acc = md == HLT || (md == RUN && c < 4) || (md >= WAI && (c == 1 || c == 3));
        omc_debug_host_inst.issue(c[2:0]);
        @(negedge pclk);
        chk("accept", cmd_accept, acc);
        chk("stop_wait_err", cmd_stop_wait_err, acc && md >= WAI && c == 1);
        chk("mem_enable", cmd_mem_enable, acc && md < WAI && c < 2);
        if (acc && c == 3) md = HLT;
        if (acc && c == 6) md = RUN;
        chk("mode", mode, md);
    endtask
    task automatic boot(input logic pin);
        @(posedge pclk);
        presetn <= 1'h0;
        mode_pin_in <= pin;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic wrap_up();
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        boot(1'h0);
        chk("mode", mode, HLT);
        chk("fetch_none", fetch_start, 0);
        dfr <= 1'h1;
        boot(1'h1);
        chk("mode_force", mode, HLT);
        dfr <= 1'h0;
        boot(1'h1);
        chk("mode", mode, RUN);
        chk("fetch", fetch_start, 1);
        chk("vector", fetch_vector, 16'hfffe);
        apb(1'h0, `OMC_ADDR_CTRL, 0);
        chk("ctrl", r, 1);
        apb(1'h1, 12'h00c, 32'hffff_ffff);
        apb(1'h0, 12'h00c, 0);
        chk("unmapped", r, 0);
        foreach (cl[j]) cmd(cl[j]);
        for (int k = 0; k < 5; k += 3 - k / 3 * 2) begin
            ev(k);
            md = HLT;
            cmd(6);
        end
        ev(1);
        chk("wait", {mode, cpu_clk_en, bus_clk_en, clear_int_mask}, 32'h0000_001b);
        md = WAI;
        cmd(0);
        cmd(1);
        ev(5);
        chk("wake", {mode, take_irq_stacking}, 32'h0000_0003);
        ev(1);
        md = WAI;
        cmd(3);
        cmd(6);
        // Stop selection over the table corners, then random control words
        for (int i = 0; i < 16; i++) begin
            cv = i < 5 ? 5'(tbl[i]) : 5'(rnd());
            apb(1'h1, `OMC_ADDR_CTRL, cv);
            em = !cv[0] ? RST : (cv[1] || (cv[2] && cv[3]) || !cv[4]) ? RET : DEP;
            ev(2);
            chk("stop_mode", mode, em);
            if (em != RST) chk("stop_clk", {bus_clk_en, cpu_clk_en}, 0);
            if (em == RST) chk("illegal", illegal_op_reset, 1);
            else if (em == DEP) begin
                chk("latch", pin_latch_closed, 1);
                chk("ram_only", ram_only_power, 1);
                ev(7);
                chk("mode", mode, RST);
            end else if (cv[1]) begin
                chk("dbg_keep", {debug_clk_en, regulator_full}, 3);
                md = RET;
                cmd(1);
                cmd(3);
                cmd(6);
            end else begin
                chk("regulator", regulator_full, cv[2] && cv[3]);
                ev(i[0] ? 6 : 8);
            end
            if (em != RET || (!cv[1] && !i[0])) @(negedge pclk);
            chk("mode", mode, RUN);
            md = RUN;
            if (em == DEP) begin
                apb(1'h0, `OMC_ADDR_STAT, 0);
                chk("status", r[7:0], 8'hc1);
                apb(1'h1, `OMC_ADDR_ACK, 1);
                apb(1'h0, `OMC_ADDR_STAT, 0);
                chk("status", {r[7:0], pin_latch_closed}, 9'h002);
            end
        end
        wrap_up();
    end
endmodule
